// [verilog/mie_cfg.svh]
// constants of the instruction execute block: file addresses, register port map,
// status bit positions, reset values and the instruction cycle length.
// assumes nothing of its surroundings; included by bare name.
`ifndef MIE_CFG_SVH
`define MIE_CFG_SVH
// file register addresses seen by instructions
`define MIE_FA_TMR 5'h01
`define MIE_FA_PCL 5'h02
`define MIE_FA_IO 5'h06
// file operand that selects the port direction latches
`define MIE_DIR_SEL 5'h06
// register port map (6-bit word addresses); 0x00..0x1f are the file registers
`define MIE_RA_ACC 6'h20
`define MIE_RA_STATUS 6'h21
`define MIE_RA_DIR 6'h22
`define MIE_RA_CTRL 6'h23
// status bit positions
`define MIE_ST_CARRY 0
`define MIE_ST_HALF 1
`define MIE_ST_ZERO 2
// ctrl bit: prescaler assigned to the timer counter register
`define MIE_CT_PRESC 0
// reset values
`define MIE_RST_ACC 8'h00
`define MIE_RST_STATUS 3'h0
`define MIE_RST_DIR 8'hff
`define MIE_RST_CTRL 1'h0
`define MIE_RST_PC 9'h000
// oscillator periods per instruction cycle and the last phase index
`define MIE_OSC_PER_CYCLE 4
`define MIE_LAST_PHASE 2'h3
`endif

// [verilog/mie_pkg.sv]
// types of the instruction execute block: operation codes and the instruction carrier.
// assumes the decoder upstream has already split the opcode into these fields.
`default_nettype none
package mie_pkg;
  typedef enum logic [3:0] {
    no_operation = 4'h0,
    add_acc_to_file = 4'h1,
    and_acc_with_file = 4'h2,
    and_literal_into_acc = 4'h3,
    bit_clear_op = 4'h4,
    bit_set_op = 4'h5,
    skip_when_bit_low = 4'h6,
    skip_when_bit_high = 4'h7,
    accumulator_zero_op = 4'h8,
    pin_direction_load = 4'h9,
    absolute_jump = 4'ha
  } mie_op_t;
  typedef struct packed {
    mie_op_t op;
    logic [4:0] faddr;
    logic [2:0] bsel;
    logic dest;
    logic [7:0] lit;
    logic [8:0] target;
  } mie_instr_t;
endpackage
`default_nettype wire

// [verilog/mie_core.sv]
// execution unit for a subset of an 8-bit microcontroller instruction set.
// assumes clk_sys_in is the oscillator; one instruction is taken per four periods.
`include "mie_cfg.svh"
`default_nettype none
module mie_core (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // instruction stream
  input wire mie_pkg::mie_instr_t instr_in,
  input wire logic instr_valid_in,
  output logic instr_ready_out,
  output logic [8:0] pc_out,
  // io port pins
  input wire logic [7:0] pins_in,
  output logic [7:0] port_drive_out,
  output logic [7:0] port_oe_n_out,
  // timer side
  output logic prescaler_clear_out,
  // register port
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  logic [1:0] phase, next_phase;
  logic flush, next_flush;
  logic [8:0] pc, next_pc;
  logic [7:0] acc, next_acc;
  logic [2:0] status, next_status;
  logic [7:0] dir, next_dir;
  logic ctrl, next_ctrl;
  logic presc, next_presc;
  logic [7:0] rdata, next_rdata;
  logic [7:0] file_q [0:31];
  logic f_we;
  logic [4:0] f_waddr;
  logic [7:0] f_wdata;
  logic sw_fwe;
  logic exec_fire;
  logic [7:0] fval;
  logic bitv;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] res;
  logic to_file;
  logic flagged;
  mie_pkg::mie_instr_t ins;

  assign ins = instr_in;
  // one instruction cycle spans four oscillator periods
  assign instr_ready_out = (phase == `MIE_LAST_PHASE);
  assign exec_fire = instr_ready_out && instr_valid_in && !flush;
  assign pc_out = pc;
  assign port_drive_out = file_q[`MIE_FA_IO];
  assign port_oe_n_out = dir;
  assign prescaler_clear_out = presc;
  assign reg_rdata_out = rdata;
  assign sw_fwe = reg_wr_in && !reg_addr_in[5];

  always_comb begin
    // the io port operand is the pin level, not the output latch
    if (ins.faddr == `MIE_FA_IO) begin
      fval = pins_in;
    end else if (ins.faddr == `MIE_FA_PCL) begin
      fval = pc[7:0];
    end else begin
      fval = file_q[ins.faddr];
    end
    bitv = fval[ins.bsel];
    sum = {1'b0, acc} + {1'b0, fval};
    half = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};
  end

  always_comb begin
    next_phase = phase + 2'h1;
    next_flush = flush;
    next_pc = pc;
    next_acc = acc;
    next_status = status;
    next_dir = dir;
    next_ctrl = ctrl;
    next_presc = 1'b0;
    f_we = 1'b0;
    f_waddr = ins.faddr;
    f_wdata = fval;
    res = 8'h00;
    to_file = 1'b0;
    flagged = 1'b0;
    // software writes land first so an instruction in the same cycle wins
    if (reg_wr_in) begin
      case (reg_addr_in)
        `MIE_RA_ACC: next_acc = reg_wdata_in;
        `MIE_RA_STATUS: next_status = reg_wdata_in[2:0];
        `MIE_RA_DIR: next_dir = reg_wdata_in;
        `MIE_RA_CTRL: next_ctrl = reg_wdata_in[`MIE_CT_PRESC];
        default: next_ctrl = ctrl;
      endcase
    end
    // the discarded slot behaves as a no-operation and holds the pc
    if (instr_ready_out && flush) begin
      next_flush = 1'b0;
    end
    if (exec_fire) begin
      next_pc = pc + 9'h001;
      case (ins.op)
        mie_pkg::add_acc_to_file: begin
          res = sum[7:0];
          to_file = ins.dest;
          flagged = ins.dest;
          next_status[`MIE_ST_CARRY] = sum[8];
          next_status[`MIE_ST_HALF] = half[4];
          next_status[`MIE_ST_ZERO] = (sum[7:0] == 8'h00);
        end
        mie_pkg::and_acc_with_file: begin
          res = acc & fval;
          to_file = ins.dest;
          flagged = ins.dest;
          next_status[`MIE_ST_ZERO] = (res == 8'h00);
        end
        mie_pkg::and_literal_into_acc: begin
          res = acc & ins.lit;
          next_status[`MIE_ST_ZERO] = (res == 8'h00);
        end
        mie_pkg::bit_clear_op: begin
          res = fval & ~(8'h01 << ins.bsel);
          to_file = 1'b1;
          flagged = 1'b1;
        end
        mie_pkg::bit_set_op: begin
          res = fval | (8'h01 << ins.bsel);
          to_file = 1'b1;
          flagged = 1'b1;
        end
        mie_pkg::skip_when_bit_low: begin
          res = acc;
          if (!bitv) begin
            next_pc = pc + 9'h002;
            next_flush = 1'b1;
          end
        end
        mie_pkg::skip_when_bit_high: begin
          res = acc;
          if (bitv) begin
            next_pc = pc + 9'h002;
            next_flush = 1'b1;
          end
        end
        mie_pkg::accumulator_zero_op: begin
          res = 8'h00;
          next_status[`MIE_ST_ZERO] = 1'b1;
        end
        mie_pkg::pin_direction_load: begin
          res = acc;
          if (ins.faddr == `MIE_DIR_SEL) begin
            next_dir = acc;
          end
        end
        mie_pkg::absolute_jump: begin
          res = acc;
          next_pc = ins.target;
          next_flush = 1'b1;
        end
        default: res = acc;
      endcase
      // destination select: file register or accumulator
      if (ins.op == mie_pkg::add_acc_to_file || ins.op == mie_pkg::and_acc_with_file) begin
        if (!ins.dest) begin
          next_acc = res;
        end
      end else if (ins.op == mie_pkg::and_literal_into_acc ||
                   ins.op == mie_pkg::accumulator_zero_op) begin
        next_acc = res;
      end
      if (to_file) begin
        if (ins.faddr == `MIE_FA_PCL) begin
          // a computed pc write drops bit 8 and costs a second cycle
          next_pc = {1'b0, res};
          next_flush = 1'b1;
        end else begin
          f_we = 1'b1;
          f_wdata = res;
        end
      end
      if (flagged && ins.faddr == `MIE_FA_TMR && ctrl) begin
        next_presc = 1'b1;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd_in) begin
      if (!reg_addr_in[5]) begin
        if (reg_addr_in[4:0] == `MIE_FA_IO) begin
          next_rdata = pins_in;
        end else if (reg_addr_in[4:0] == `MIE_FA_PCL) begin
          next_rdata = pc[7:0];
        end else begin
          next_rdata = file_q[reg_addr_in[4:0]];
        end
      end else begin
        case (reg_addr_in)
          `MIE_RA_ACC: next_rdata = acc;
          `MIE_RA_STATUS: next_rdata = {5'h00, status};
          `MIE_RA_DIR: next_rdata = dir;
          `MIE_RA_CTRL: next_rdata = {7'h00, ctrl};
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase <= 2'h0;
      flush <= 1'b0;
      pc <= `MIE_RST_PC;
      acc <= `MIE_RST_ACC;
      status <= `MIE_RST_STATUS;
      dir <= `MIE_RST_DIR;
      ctrl <= `MIE_RST_CTRL;
      presc <= 1'b0;
      rdata <= 8'h00;
    end else begin
      phase <= next_phase;
      flush <= next_flush;
      pc <= next_pc;
      acc <= next_acc;
      status <= next_status;
      dir <= next_dir;
      ctrl <= next_ctrl;
      presc <= next_presc;
      rdata <= next_rdata;
    end
  end

  // instruction write is applied after the software write so it wins a collision
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 32; i++) begin
        file_q[i] <= 8'h00;
      end
    end else begin
      if (sw_fwe) begin
        file_q[reg_addr_in[4:0]] <= reg_wdata_in;
      end
      if (f_we) begin
        file_q[f_waddr] <= f_wdata;
      end
    end
  end

  property p_pc_bit8;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && to_file && ins.faddr == `MIE_FA_PCL |=> pc[8] == 1'b0 && flush;
  endproperty
  a_pc_bit8: assert property (p_pc_bit8) else $error("pc bit 8 not cleared");
  property p_pin_rmw;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::bit_set_op && ins.faddr == `MIE_FA_IO
      |=> port_drive_out == ($past(pins_in) | (8'h01 << $past(ins.bsel)));
  endproperty
  a_pin_rmw: assert property (p_pin_rmw) else $error("io rmw not from pins");
  property p_dir_load;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::pin_direction_load && ins.faddr == `MIE_DIR_SEL
      |=> port_oe_n_out == $past(acc);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong");
  property p_presc;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && (ins.op == mie_pkg::bit_clear_op || ins.op == mie_pkg::bit_set_op) &&
      ins.faddr == `MIE_FA_TMR && ctrl |=> prescaler_clear_out ##1 !prescaler_clear_out;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler not cleared");
  property p_add_acc;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::add_acc_to_file && !ins.dest
      |=> {status[`MIE_ST_CARRY], acc} == {1'b0, $past(acc)} + {1'b0, $past(fval)};
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("add result wrong");
  property p_bclr_flags;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::bit_clear_op && !reg_wr_in |=> $stable(status);
  endproperty
  a_bclr_flags: assert property (p_bclr_flags) else $error("bit clear moved flags");
  property p_and_literal_into_acc;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::and_literal_into_acc
      |=> acc == ($past(acc) & $past(ins.lit)) && status[`MIE_ST_ZERO] == (acc == 8'h00);
  endproperty
  a_and_literal_into_acc: assert property (p_and_literal_into_acc) else $error("literal and wrong");
  property p_skip_low;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::skip_when_bit_low && !bitv
      |=> flush [*4] ##1 !flush;
  endproperty
  a_skip_low: assert property (p_skip_low) else $error("skip slot wrong");
  property p_accumulator_zero_op;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::accumulator_zero_op |=> acc == 8'h00 && status[`MIE_ST_ZERO];
  endproperty
  a_accumulator_zero_op: assert property (p_accumulator_zero_op) else $error("accumulator clear wrong");
  property p_cycle;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    instr_ready_out |=> !instr_ready_out [*3] ##1 instr_ready_out;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle not four periods");
  c_skip_high: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::skip_when_bit_high && bitv);
  c_jump: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::absolute_jump);
  c_add_carry: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    exec_fire && ins.op == mie_pkg::add_acc_to_file && sum[8]);
endmodule
`default_nettype wire

// [tb/tb_mie_core.sv]
// self-checking bench for the instruction execute block, driven straight at its ports.
// assumes mie_pkg and mie_core are compiled first; register reads are checked a cycle late.
`default_nettype none
module tb_mie_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  mie_pkg::mie_instr_t instr_in = '0;
  logic instr_valid_in = 1'b0;
  logic [7:0] pins_in = 8'h00;
  logic [5:0] reg_addr_in = 6'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic instr_ready_out;
  logic [8:0] pc_out;
  logic [7:0] port_drive_out, port_oe_n_out, reg_rdata_out;
  logic prescaler_clear_out;
  logic rd_seen = 1'b0;
  logic [13:0] e;
  logic [13:0] exp_q[$];
  logic [7:0] a, f, r;
  logic [8:0] s;
  int fail_count = 0;
  int n_compared = 0;
  int presc_n = 0;

  mie_core u_mie_core (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out), .pc_out(pc_out),
    .pins_in(pins_in), .port_drive_out(port_drive_out), .port_oe_n_out(port_oe_n_out),
    .prescaler_clear_out(prescaler_clear_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out));

  always #2 clk_sys_in = ~clk_sys_in;

  task automatic check(input string what, input logic [8:0] x, input logic [8:0] got);
    n_compared++;
    if (got !== x) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, x, got);
    end
  endtask

  // read data stand only in the cycle after the strobe, so compare there
  always @(posedge clk_sys_in) rd_seen <= reg_rd_in;
  always @(negedge clk_sys_in) begin
    if (prescaler_clear_out === 1'b1) presc_n++;
    if (rd_seen) begin
      e = exp_q.pop_front();
      check($sformatf("reg %h", e[13:8]), {1'b0, e[7:0]}, {1'b0, reg_rdata_out});
    end
  end

  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    exp_q.push_back({ad, d});
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
  endtask

  // valid is held until the ready edge takes the instruction
  task automatic op(input mie_pkg::mie_op_t o, input logic [4:0] fa, input logic [2:0] b,
                    input logic d, input logic [8:0] k);
    logic seen = 1'b0;
    @(posedge clk_sys_in);
    instr_in <= '{o, fa, b, d, k[7:0], k};
    instr_valid_in <= 1'b1;
    repeat (8) begin
      @(negedge clk_sys_in);
      if (instr_ready_out === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    // a missing ready is a mismatch, not a silent skip
    if (!seen) begin
      fail_count++;
      $display("FAIL ready expected 1 seen 0");
    end
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
  endtask

  task automatic opc(input mie_pkg::mie_op_t o, input logic [4:0] fa, input logic [2:0] b,
                     input logic [8:0] k, input logic [8:0] pc_x);
    op(o, fa, b, 1'b1, k);
    @(negedge clk_sys_in);
    check("pc", pc_x, pc_out);
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #80000;
    fail_count++;
    summarize();
  end

  initial begin
    a = 8'($urandom(32'h5612));
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(6'h20, 8'h00);
    rd(6'h21, 8'h00);
    rd(6'h22, 8'hff);
    rd(6'h23, 8'h00);
    wr(6'h30, 8'h5a);
    rd(6'h30, 8'h00);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'hff : 8'($urandom);
      f = (i == 0) ? 8'h01 : 8'($urandom);
      wr(6'h20, a);
      wr(6'h03, f);
      op(mie_pkg::add_acc_to_file, 5'h03, 3'h0, i[0], 9'h000);
      s = a + f;
      rd(i[0] ? 6'h03 : 6'h20, s[7:0]);
      rd(i[0] ? 6'h20 : 6'h03, i[0] ? a : f);
      rd(6'h21, {s[7:0] == 8'h00, (a[3:0] + f[3:0]) > 5'h0f, s[8]});
    end
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      f = (i == 0) ? ~a : 8'($urandom);
      wr(6'h20, a);
      wr(6'h04, f);
      wr(6'h21, 8'h03);
      op(mie_pkg::and_acc_with_file, 5'h04, 3'h0, i[0], 9'h000);
      r = i[0] ? a : (a & f);
      rd(i[0] ? 6'h04 : 6'h20, a & f);
      rd(6'h21, {(a & f) == 8'h00, 2'b11});
      wr(6'h21, 8'h03);
      op(mie_pkg::and_literal_into_acc, 5'h00, 3'h0, 1'b0, {1'b0, f});
      rd(6'h20, r & f);
      rd(6'h21, {(r & f) == 8'h00, 2'b11});
    end
    for (int b = 0; b < 8; b++) begin
      f = 8'($urandom);
      r = 8'($urandom);
      wr(6'h05, f);
      wr(6'h07, f);
      wr(6'h21, {5'h00, r[2:0]});
      op(mie_pkg::bit_clear_op, 5'h05, b[2:0], 1'b0, 9'h000);
      op(mie_pkg::bit_set_op, 5'h07, b[2:0], 1'b0, 9'h000);
      rd(6'h05, f & ~(8'h01 << b));
      rd(6'h07, f | (8'h01 << b));
      rd(6'h21, {5'h00, r[2:0]});
    end
    wr(6'h20, 8'hff);
    wr(6'h21, 8'h00);
    op(mie_pkg::accumulator_zero_op, 5'h00, 3'h0, 1'b0, 9'h000);
    rd(6'h20, 8'h00);
    rd(6'h21, 8'h04);
    // a dropped slot must leave both pc and the accumulator alone
    wr(6'h08, 8'h5a);
    wr(6'h20, 8'h33);
    opc(mie_pkg::absolute_jump, 5'h00, 3'h0, 9'h1f0, 9'h1f0);
    opc(mie_pkg::and_literal_into_acc, 5'h00, 3'h0, 9'h000, 9'h1f0);
    opc(mie_pkg::skip_when_bit_low, 5'h08, 3'h0, 9'h000, 9'h1f2);
    opc(mie_pkg::and_literal_into_acc, 5'h00, 3'h0, 9'h000, 9'h1f2);
    opc(mie_pkg::skip_when_bit_high, 5'h08, 3'h1, 9'h000, 9'h1f4);
    opc(mie_pkg::and_literal_into_acc, 5'h00, 3'h0, 9'h000, 9'h1f4);
    rd(6'h20, 8'h33);
    opc(mie_pkg::skip_when_bit_low, 5'h08, 3'h1, 9'h000, 9'h1f5);
    opc(mie_pkg::skip_when_bit_high, 5'h08, 3'h0, 9'h000, 9'h1f6);
    opc(mie_pkg::and_literal_into_acc, 5'h00, 3'h0, 9'h00f, 9'h1f7);
    rd(6'h20, 8'h03);
    opc(mie_pkg::accumulator_zero_op, 5'h00, 3'h0, 9'h000, 9'h1f8);
    opc(mie_pkg::and_acc_with_file, 5'h02, 3'h0, 9'h000, 9'h000);
    opc(mie_pkg::no_operation, 5'h00, 3'h0, 9'h000, 9'h000);
    r = 8'($urandom) & 8'h7f;
    pins_in <= r;
    wr(6'h06, ~r);
    op(mie_pkg::bit_set_op, 5'h06, 3'h7, 1'b0, 9'h000);
    @(negedge clk_sys_in);
    check("port latch", {1'b0, r | 8'h80}, {1'b0, port_drive_out});
    r = 8'($urandom);
    wr(6'h20, r);
    op(mie_pkg::pin_direction_load, 5'h06, 3'h0, 1'b0, 9'h000);
    rd(6'h22, r);
    // a different accumulator makes a wrongly taken load visible
    wr(6'h20, ~r);
    op(mie_pkg::pin_direction_load, 5'h05, 3'h0, 1'b0, 9'h000);
    @(negedge clk_sys_in);
    check("direction", {1'b0, r}, {1'b0, port_oe_n_out});
    for (int c = 0; c < 5; c++) begin
      wr(6'h23, {7'h00, c[1] | c[2]});
      presc_n = 0;
      op(c[2] ? mie_pkg::bit_clear_op : mie_pkg::add_acc_to_file, 5'h01, 3'h2, c[0], 9'h000);
      repeat (4) @(negedge clk_sys_in);
      check("prescaler pulses", (c >= 3) ? 9'h001 : 9'h000, 9'(presc_n));
    end
    repeat (4) @(posedge clk_sys_in);
    summarize();
  end
endmodule
`default_nettype wire
